// [sach_assertions.sv]
`timescale 1ns/1ns
module sach_assertions #(
	parameter SIL_UNIT_CYCLES = 50
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// watched ports
	input wire slave_select_line_n,
	input wire spi_miso_oe,
	input wire ready_busy_line,
	input wire command_busy_flag,
	input wire [15:0] lookup_sector,
	input wire play_start,
	input wire play_done,
	input wire silence_active,
	input wire erase_start,
	input wire [15:0] erase_sector,
	input wire erase_done,
	input wire command_finished_irq,
	input wire command_error_irq,
	input wire address_error_irq
);
	// ----------------------------------------
	// engine tracking
	// ----------------------------------------
	logic erasing;
	logic playing;
	logic [31:0] sil_cnt;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			erasing <= 1'b0;
			playing <= 1'b0;
			sil_cnt <= 32'h0;
		end else begin
			erasing <= erase_start | (erasing & ~erase_done);
			playing <= play_start | (playing & ~play_done);
			sil_cnt <= silence_active ? sil_cnt + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_erase_end;
		erasing && erase_done;
	endsequence
	sequence s_play_end;
		playing && play_done;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_sil_fin: assert property ($fell(silence_active) |-> ##[0:1] command_finished_irq)
		else $error("silence ended without finish");
	a_sil_cap: assert property (silence_active |-> sil_cnt < 255 * SIL_UNIT_CYCLES)
		else $error("silence too long");
	a_err_quiet: assert property (command_error_irq |->
		(!play_start && !erase_start) ##1 (!play_start && !erase_start))
		else $error("refused command started");
	a_addr_quiet: assert property (address_error_irq |-> !play_start && !erase_start)
		else $error("bad address command started");
	a_erase_hold: assert property (erasing && $past(erasing) |->
		!ready_busy_line && !play_start && command_busy_flag)
		else $error("activity during erase");
	a_erase_sec: assert property (erase_start |-> erase_sector == lookup_sector)
		else $error("erase sector differs");
	a_erase_fin: assert property (s_erase_end |=> command_finished_irq)
		else $error("erase finish missing");
	a_play_fin: assert property (s_play_end |=> command_finished_irq)
		else $error("play finish missing");
	a_oe_sel: assert property ($stable(slave_select_line_n) [*5] |->
		spi_miso_oe == !slave_select_line_n)
		else $error("reply enable wrong");
endmodule // sach_assertions

// [sach_core.v]
`timescale 1ns/1ns
`include "sach_defines.vh"
// Functional notes
// RULE1 - play sector is address/4096 plus offset
// RULE2 - low twelve address bits are ignored
// RULE3 - play with under five bytes is dropped
// RULE4 - play/silence accepted only when flags allow
// RULE5 - bad start sector or offset: address error
// RULE6 - command byte only: no interrupt at all
// RULE7 - silence lasts length times 32 ms
// RULE8 - stop raises nothing; stopped command finishes
// RULE9 - stop halts playback and silence at once
// RULE10 - stop ends recording at byte boundary
// RULE11 - stop flushes the queued commands
// RULE12 - stop spares erase; idle stop does nothing
// RULE13 - erase accepted also needs command not busy
// RULE14 - erase: bad sector error, finish on completion
// RULE15 - play during erase waits until erase ends
// RULE16 - ready/busy held low during erase
// RULE17 - host sends samples low byte first
// RULE18 - host records: path, record, audio, stop
// RULE19 - memory full: error, further audio refused
// RULE20 - feed-through paced at sample rate
// RULE21 - after deselect feed-through outputs zeros
// RULE22 - busy when full or no path; overflow error
// RULE23 - status byte returned for every byte
module sach_core #(
	parameter SIL_UNIT_CYCLES = `SACH_SIL_UNIT_CYCLES
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// serial host port
	input wire spi_sclk,
	input wire slave_select_line_n,
	input wire spi_mosi,
	output reg spi_miso,
	output reg spi_miso_oe,
	output reg ready_busy_line,
	// device status flags
	input wire power_down_flag,
	input wire buffer_ready_flag,
	input wire macro_busy_flag,
	input wire command_buffer_full_flag,
	output reg command_busy_flag,
	// message directory lookup
	output reg [15:0] lookup_sector,
	input wire msg_is_start,
	input wire [15:0] msg_length,
	// playback engine
	output reg play_start,
	output reg play_stop,
	output reg [15:0] play_sector,
	input wire play_done,
	output reg silence_active,
	// erase engine
	output reg erase_start,
	output reg [15:0] erase_sector,
	input wire erase_done,
	// recorder
	input wire record_active,
	input wire record_done,
	input wire memory_full,
	output reg record_stop,
	output reg queue_flush,
	// audio path
	input wire [1:0] path_mode,
	input wire [15:0] sample_period_cycles,
	input wire comp_ready,
	output reg [15:0] pcm_data,
	output reg pcm_valid,
	// interrupt events
	output reg command_finished_irq,
	output reg command_error_irq,
	output reg address_error_irq,
	output reg overflow_error_irq,
	output reg memory_full_irq
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_CMD = 3'h0;
	localparam ST_PLAY = 3'h1;
	localparam ST_SIL = 3'h2;
	localparam ST_ERASE = 3'h3;
	localparam ST_AUDIO = 3'h4;
	localparam ST_IGNORE = 3'h5;
	// ----------------------------------------
	// input synchronisers and edges
	// ----------------------------------------
	reg sclk_m, sclk_s, sclk_d;
	reg ss_m, ss_s, ss_d;
	reg mosi_m, mosi_s;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire ss_fall = ~ss_s & ss_d;
	wire ss_rise = ss_s & ~ss_d;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			ss_m <= 1'b1;
			ss_s <= 1'b1;
			ss_d <= 1'b1;
			mosi_m <= 1'b0;
			mosi_s <= 1'b0;
		end else begin
			sclk_m <= spi_sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			ss_m <= slave_select_line_n;
			ss_s <= ss_m;
			ss_d <= ss_s;
			mosi_m <= spi_mosi;
			mosi_s <= mosi_m;
		end
	end
	// ----------------------------------------
	// shared state
	// ----------------------------------------
	reg [2:0] bitcnt;
	reg [7:0] rx_sh;
	reg [7:0] tx_sh;
	reg [2:0] state;
	reg [2:0] argcnt;
	reg [39:0] args;
	reg [7:0] pcm_low;
	reg chk_play, chk_erase, play_pend, play_active, erase_active;
	reg [15:0] pend_sector;
	reg [7:0] sil_left;
	reg [31:0] sil_cnt;
	reg smp_full, mem_refuse;
	reg [15:0] smp_data;
	reg [15:0] tick_cnt;
	wire [7:0] rx_byte = {rx_sh[6:0], mosi_s};
	wire byte_done = sclk_rise & ~ss_s & (bitcnt == 3'h7);
	wire flags_ok = ~power_down_flag & buffer_ready_flag & ~macro_busy_flag &
		~command_buffer_full_flag;
	wire busy_now = play_active | silence_active | erase_active | play_pend |
		record_active;
	wire tick = (tick_cnt == 16'h0000);
	wire [7:0] status = {power_down_flag, buffer_ready_flag, macro_busy_flag,
		command_buffer_full_flag, command_busy_flag, play_active, erase_active,
		mem_refuse};
	wire is_stop = byte_done & (state == ST_CMD) & (rx_byte == `SACH_OP_STOP);
	wire sil_end = silence_active & (sil_cnt == 32'h0) & (sil_left == 8'h01);
	wire path_ok = (path_mode == `SACH_PATH_FEED) |
		((path_mode == `SACH_PATH_RECORD) & record_active);
	wire smp_in = byte_done & (state == ST_AUDIO) & argcnt[0];
	wire drain = smp_full & (((path_mode == `SACH_PATH_FEED) & tick) |
		((path_mode == `SACH_PATH_RECORD) & record_active & comp_ready));
	// ----------------------------------------
	// serial shifting and status replies
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!rst_n) begin
			bitcnt <= 3'h0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= ~ss_s;
			if (ss_s) begin
				bitcnt <= 3'h0;
			end else if (sclk_rise) begin
				rx_sh <= rx_byte;
				bitcnt <= bitcnt + 3'h1;
			end
			if (ss_fall | byte_done) begin
				tx_sh <= status; // [RULE23]
				spi_miso <= status[7];
			end else if (sclk_fall & ~ss_s & (bitcnt != 3'h0)) begin
				tx_sh <= {tx_sh[6:0], 1'b0};
				spi_miso <= tx_sh[6];
			end
		end
	end
	// ----------------------------------------
	// command interpreter
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_CMD;
			argcnt <= 3'h0;
			args <= 40'h0;
			pcm_low <= 8'h00;
			chk_play <= 1'b0;
			chk_erase <= 1'b0;
			command_error_irq <= 1'b0;
			play_stop <= 1'b0;
			record_stop <= 1'b0;
			queue_flush <= 1'b0;
			silence_active <= 1'b0;
			sil_left <= 8'h00;
			sil_cnt <= 32'h0;
		end else begin
			chk_play <= 1'b0;
			chk_erase <= 1'b0;
			command_error_irq <= 1'b0;
			play_stop <= 1'b0;
			record_stop <= 1'b0;
			queue_flush <= 1'b0;
			if (ss_rise) begin
				state <= ST_CMD; // [RULE3] [RULE6]
			end else if (byte_done) begin
				case (state)
				ST_CMD: begin
					argcnt <= 3'h0;
					case (rx_byte)
					`SACH_OP_PLAY_AT_ADDR: state <= ST_PLAY;
					`SACH_OP_PLAY_SILENCE: state <= ST_SIL;
					`SACH_OP_ERASE_AT_ADDR: state <= ST_ERASE;
					`SACH_OP_SEND_PCM: state <= ST_AUDIO;
					`SACH_OP_STOP: begin
						state <= ST_IGNORE;
						play_stop <= play_active; // [RULE9] [RULE12]
						record_stop <= record_active; // [RULE10]
						queue_flush <= busy_now; // [RULE11]
					end
					default: state <= ST_IGNORE;
					endcase
				end
				ST_PLAY: begin
					args <= {args[31:0], rx_byte};
					argcnt <= argcnt + 3'h1;
					if (argcnt == `SACH_PLAY_ARG_LAST) begin
						state <= ST_IGNORE;
						chk_play <= flags_ok; // [RULE4]
						command_error_irq <= ~flags_ok; // [RULE4]
					end
				end
				ST_SIL: begin
					state <= ST_IGNORE;
					command_error_irq <= ~flags_ok; // [RULE4]
					if (flags_ok && rx_byte != 8'h00) begin
						silence_active <= 1'b1; // [RULE7]
						sil_left <= rx_byte;
						sil_cnt <= SIL_UNIT_CYCLES - 1;
					end
				end
				ST_ERASE: begin
					args <= {args[31:0], rx_byte};
					argcnt <= argcnt + 3'h1;
					if (argcnt == `SACH_ERASE_ARG_LAST) begin
						state <= ST_IGNORE;
						chk_erase <= flags_ok & ~command_busy_flag; // [RULE13]
						command_error_irq <= ~(flags_ok & ~command_busy_flag);
					end
				end
				ST_AUDIO: begin
					argcnt <= {2'b00, ~argcnt[0]};
					if (!argcnt[0])
						pcm_low <= rx_byte; // [RULE17]
				end
				default: state <= ST_IGNORE;
				endcase
			end
			// silence countdown in 32 ms units
			if (silence_active) begin
				if (is_stop | sil_end) begin
					silence_active <= 1'b0; // [RULE7] [RULE9]
				end else if (sil_cnt == 32'h0) begin
					sil_cnt <= SIL_UNIT_CYCLES - 1;
					sil_left <= sil_left - 8'h01;
				end else begin
					sil_cnt <= sil_cnt - 32'h1;
				end
			end
		end
	end
	// ----------------------------------------
	// address checks, play and erase control
	// ----------------------------------------
	reg chk_play_d, chk_erase_d;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			lookup_sector <= 16'h0000;
			chk_play_d <= 1'b0;
			chk_erase_d <= 1'b0;
			play_start <= 1'b0;
			play_sector <= 16'h0000;
			play_active <= 1'b0;
			play_pend <= 1'b0;
			pend_sector <= 16'h0000;
			erase_start <= 1'b0;
			erase_sector <= 16'h0000;
			erase_active <= 1'b0;
			address_error_irq <= 1'b0;
			command_finished_irq <= 1'b0;
			command_busy_flag <= 1'b0;
		end else begin
			chk_play_d <= chk_play;
			chk_erase_d <= chk_erase;
			play_start <= 1'b0;
			erase_start <= 1'b0;
			address_error_irq <= 1'b0;
			command_busy_flag <= busy_now;
			if (chk_play)
				lookup_sector <= {4'h0, args[39:28]}; // [RULE1] [RULE2]
			else if (chk_erase)
				lookup_sector <= {4'h0, args[23:12]}; // [RULE2]
			// clear first so a new start in the same cycle wins
			if (play_done)
				play_active <= 1'b0;
			if (chk_play_d) begin
				if (!msg_is_start || args[15:0] > msg_length) begin
					address_error_irq <= 1'b1; // [RULE5]
				end else if (erase_active) begin
					play_pend <= 1'b1; // [RULE15]
					pend_sector <= lookup_sector + args[15:0];
				end else begin
					play_start <= 1'b1;
					play_active <= 1'b1;
					play_sector <= lookup_sector + args[15:0]; // [RULE1]
				end
			end else if (play_pend & ~erase_active & ~is_stop) begin
				play_pend <= 1'b0; // [RULE15]
				play_start <= 1'b1;
				play_active <= 1'b1;
				play_sector <= pend_sector;
			end else if (is_stop) begin
				play_pend <= 1'b0; // [RULE11]
			end
			if (chk_erase_d) begin
				if (!msg_is_start) begin
					address_error_irq <= 1'b1; // [RULE14]
				end else begin
					erase_start <= 1'b1;
					erase_active <= 1'b1;
					erase_sector <= lookup_sector;
				end
			end else if (erase_done) begin
				erase_active <= 1'b0;
			end
			// stop itself reports nothing; the stopped command does
			command_finished_irq <= play_done | erase_done | record_done |
				(silence_active & (is_stop | sil_end)); // [RULE8] [RULE14]
		end
	end
	// ----------------------------------------
	// sample holding, pacing and flow control
	// ----------------------------------------
	reg mem_full_d;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			smp_full <= 1'b0;
			smp_data <= 16'h0000;
			tick_cnt <= 16'h0000;
			pcm_data <= 16'h0000;
			pcm_valid <= 1'b0;
			mem_refuse <= 1'b0;
			mem_full_d <= 1'b0;
			memory_full_irq <= 1'b0;
			overflow_error_irq <= 1'b0;
			ready_busy_line <= 1'b0;
		end else begin
			pcm_valid <= 1'b0;
			overflow_error_irq <= 1'b0;
			mem_full_d <= memory_full;
			memory_full_irq <= memory_full & ~mem_full_d & record_active; // [RULE19]
			if (memory_full & record_active)
				mem_refuse <= 1'b1; // [RULE19]
			else if (!record_active)
				mem_refuse <= 1'b0;
			if (tick)
				tick_cnt <= sample_period_cycles - 16'h0001; // [RULE20]
			else
				tick_cnt <= tick_cnt - 16'h0001;
			if (path_mode == `SACH_PATH_FEED && tick && !smp_full) begin
				pcm_data <= 16'h0000; // [RULE21]
				pcm_valid <= 1'b1;
			end
			if (drain) begin
				pcm_data <= smp_data;
				pcm_valid <= 1'b1;
				smp_full <= 1'b0;
			end
			if (smp_in) begin
				if (smp_full | ~path_ok | erase_active) begin
					overflow_error_irq <= 1'b1; // [RULE22]
				end else if (!mem_refuse) begin
					smp_full <= 1'b1; // [RULE19]
					smp_data <= {rx_byte, pcm_low}; // [RULE17]
				end
			end
			ready_busy_line <= ~smp_full & path_ok & ~erase_active & ~mem_refuse &
				~(smp_in & ~drain); // [RULE16] [RULE22]
		end
	end
endmodule // sach_core

// [sach_core_bench.sv]
`timescale 1ns/1ns
module sach_core_bench;
	localparam int SIL = 50;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] fl = 4'b0100;
	logic msg_is_start = 1'b1, play_done = 1'b0, erase_done = 1'b0;
	logic record_active = 1'b0, record_done = 1'b0, memory_full = 1'b0, comp_ready = 1'b1;
	logic [1:0] path_mode = 2'h0;
	logic [15:0] msg_length = 16'h0010, sample_period_cycles = 16'h0014;
	wire spi_sclk, slave_select_line_n, spi_mosi, spi_miso, spi_miso_oe, ready_busy_line;
	wire command_busy_flag, play_start, play_stop, silence_active, erase_start;
	wire record_stop, queue_flush, pcm_valid, command_finished_irq, command_error_irq;
	wire address_error_irq, overflow_error_irq, memory_full_irq;
	wire [15:0] lookup_sector, play_sector, erase_sector, pcm_data;
	logic [9:0] seen = 10'h000;
	logic [15:0] last_pcm = 16'h0000;
	int n_mismatch = 0, compares = 0, cyc = 0, sil_n = 0, zc = 0;
	sach_host host_u (.spi_sclk, .slave_select_line_n, .spi_mosi, .spi_miso, .ready_busy_line);
	sach_core #(.SIL_UNIT_CYCLES(SIL)) dut_u (.core_clk, .rst_n, .spi_sclk,
		.slave_select_line_n, .spi_mosi, .spi_miso, .spi_miso_oe, .ready_busy_line,
		.power_down_flag(fl[3]), .buffer_ready_flag(fl[2]), .macro_busy_flag(fl[1]),
		.command_buffer_full_flag(fl[0]), .command_busy_flag, .lookup_sector,
		.msg_is_start, .msg_length, .play_start, .play_stop, .play_sector, .play_done,
		.silence_active, .erase_start, .erase_sector, .erase_done, .record_active,
		.record_done, .memory_full, .record_stop, .queue_flush, .path_mode,
		.sample_period_cycles, .comp_ready, .pcm_data, .pcm_valid, .command_finished_irq,
		.command_error_irq, .address_error_irq, .overflow_error_irq, .memory_full_irq);
	// ----------------------------------------
	// clock and monitors
	// ----------------------------------------
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		seen <= seen | {memory_full_irq, record_stop, command_finished_irq,
			command_error_irq, address_error_irq,
			overflow_error_irq, play_start, play_stop, queue_flush, erase_start};
		if (silence_active)
			sil_n <= sil_n + 1;
		if (pcm_valid && pcm_data != 16'h0)
			last_pcm <= pcm_data;
		if (pcm_valid && pcm_data == 16'h0)
			zc <= zc + 1;
		if (cyc == 30000) begin
			$display("MISMATCH %0t timeout", $time);
			n_mismatch++;
			end_sim;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task fr(input logic [7:0] b[$], input bit pace = 1'b0);
		seen = 10'h000;
		sil_n = 0;
		host_u.frame(b, pace);
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	task play(input logic [7:0] a2, input logic [7:0] a1, input logic [7:0] a0,
		input logic [7:0] off);
		fr('{8'h3c, a2, a1, a0, 8'h00, off});
	endtask
	task automatic pulse(ref logic s);
		seen = 10'h000;
		s = 1'b1;
		@(posedge core_clk);
		#1 s = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		fr('{8'h2a});
		chk(host_u.rx, 8'h40);
		chk(seen, 8'h00);
		fr('{8'h3c});
		chk(seen, 8'h00);
		fr('{8'h3c, 8'h00, 8'h10, 8'h00, 8'h00});
		chk(seen, 8'h00);
		for (int k = 0; k < 4; k++) begin
			fl = 4'b0100 ^ (4'b1000 >> k);
			play(8'h00, 8'h10, 8'h00, 8'h00);
			chk(seen, 8'h40);
		end
		fl = 4'b0100;
		msg_is_start = 1'b0;
		play(8'h00, 8'h10, 8'h00, 8'h00);
		chk(seen, 8'h20);
		msg_is_start = 1'b1;
		msg_length = 16'h0002;
		play(8'h00, 8'h10, 8'h00, 8'h03);
		chk(seen, 8'h20);
		msg_length = 16'h0010;
		play(8'h12, 8'h34, 8'h56, 8'h03);
		chk(lookup_sector, 16'h0123);
		chk(play_sector, 16'h0126);
		fr('{8'h3e, 8'h00, 8'h50, 8'h00});
		chk(seen, 8'h40);
		fr('{8'h2a});
		chk(seen, 8'h06);
		pulse(play_done);
		chk(seen, 8'h80);
		fr('{8'h3e, 8'h00, 8'h50, 8'h00});
		chk(erase_sector, 16'h0005);
		play(8'h00, 8'h50, 8'h00, 8'h00);
		chk(seen, 8'h00);
		chk(ready_busy_line, 1'b0);
		pulse(erase_done);
		chk(seen, 8'h88);
		fr('{8'h2a});
		pulse(play_done);
		chk(seen, 8'h80);
		fr('{8'h3e, 8'h00, 8'h50, 8'h00});
		fr('{8'h2a});
		chk(seen & 8'h84, 8'h00);
		pulse(erase_done);
		chk(seen, 8'h80);
		fr('{8'ha8, 8'h02});
		repeat (110) @(posedge core_clk);
		#1;
		chk(sil_n, 2 * SIL);
		chk(seen, 8'h80);
		fr('{8'ha8, 8'h05});
		fr('{8'h2a});
		chk(silence_active, 1'b0);
		chk(seen & 8'h80, 8'h80);
		fr('{8'haa, 8'h01, 8'h02});
		chk(seen, 8'h10);
		path_mode = 2'h1;
		fr('{8'haa, 8'h34, 8'h12}, 1'b1);
		repeat (60) @(posedge core_clk);
		#1;
		chk(last_pcm, 16'h1234);
		zc = 0;
		repeat (60) @(posedge core_clk);
		#1;
		chk(zc >= 2, 1'b1);
		// recording path: held sample, memory full, stop, finish
		path_mode = 2'h2;
		record_active = 1'b1;
		comp_ready = 1'b0;
		fr('{8'haa, 8'h78, 8'h56}, 1'b1);
		chk(ready_busy_line, 1'b0);
		comp_ready = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk(last_pcm, 16'h5678);
		memory_full = 1'b1;
		fr('{8'haa, 8'h22, 8'h11});
		chk(seen, 16'h0200);
		chk(last_pcm, 16'h5678);
		chk(ready_busy_line, 1'b0);
		fr('{8'h2a});
		chk(seen, 16'h0102);
		record_active = 1'b0;
		pulse(record_done);
		chk(seen, 16'h0080);
		end_sim;
	end
endmodule // sach_core_bench
bind sach_core sach_assertions #(.SIL_UNIT_CYCLES(SIL_UNIT_CYCLES)) chk_u (.core_clk, .rst_n,
	.slave_select_line_n, .spi_miso_oe, .ready_busy_line, .command_busy_flag,
	.lookup_sector, .play_start, .play_done, .silence_active, .erase_start,
	.erase_sector, .erase_done, .command_finished_irq, .command_error_irq,
	.address_error_irq);

// [sach_defines.vh]
`ifndef SACH_DEFINES_VH
`define SACH_DEFINES_VH
// ----------------------------------------
// command opcodes
// ----------------------------------------
`define SACH_OP_PLAY_AT_ADDR 8'h3c
`define SACH_OP_PLAY_SILENCE 8'ha8
`define SACH_OP_STOP 8'h2a
`define SACH_OP_ERASE_AT_ADDR 8'h3e
`define SACH_OP_SEND_PCM 8'haa
// ----------------------------------------
// argument counts and address layout
// ----------------------------------------
`define SACH_PLAY_ARG_LAST 3'h4
`define SACH_ERASE_ARG_LAST 3'h2
`define SACH_SECTOR_LSB 12
// ----------------------------------------
// status byte bit positions
// ----------------------------------------
`define SACH_ST_POWER_DOWN 7
`define SACH_ST_BUF_READY 6
`define SACH_ST_MACRO_BUSY 5
`define SACH_ST_CBUF_FULL 4
`define SACH_ST_CMD_BUSY 3
`define SACH_ST_PLAYING 2
`define SACH_ST_ERASING 1
`define SACH_ST_MEM_FULL 0
// ----------------------------------------
// timing
// ----------------------------------------
`define SACH_CLK_KHZ 250000
`define SACH_SIL_UNIT_MS 32
`define SACH_SIL_UNIT_CYCLES (`SACH_SIL_UNIT_MS * `SACH_CLK_KHZ)
// ----------------------------------------
// audio path modes
// ----------------------------------------
`define SACH_PATH_NONE 2'h0
`define SACH_PATH_FEED 2'h1
`define SACH_PATH_RECORD 2'h2
`endif

// [sach_host.sv]
`timescale 1ns/1ns
module sach_host (
	// serial lines
	output logic spi_sclk,
	output logic slave_select_line_n,
	output logic spi_mosi,
	// device replies
	input wire spi_miso,
	input wire ready_busy_line
);
	logic [7:0] rx;
	initial begin
		spi_sclk = 1'b0;
		slave_select_line_n = 1'b1;
		spi_mosi = 1'b0;
		rx = 8'h00;
	end
	// one frame, mode 0, msb first; clock idles low
	task automatic frame(input logic [7:0] q[$], input bit pace);
		slave_select_line_n = 1'b0;
		foreach (q[i]) begin
			if (pace && i > 0)
				wait (ready_busy_line);
			for (int b = 7; b >= 0; b--) begin
				spi_mosi = q[i][b];
				#24 spi_sclk = 1'b1;
				if (i == 0)
					rx[b] = spi_miso;
				#24 spi_sclk = 1'b0;
			end
		end
		#24 slave_select_line_n = 1'b1;
	endtask
endmodule // sach_host
